/* ctm_pkg.sv */
// Shared constants and types for the compact timer block
package ctm_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMPA  = 8'h0C;
  localparam logic [7:0] OFS_CMPP  = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;

  // Field positions
  localparam int ENABLE_BIT = 3;
  localparam int PRESC_LSB  = 4;
  localparam int PRESC_W    = 3;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;

  // Reset values
  localparam logic [7:0]  CTRL1_RST = 8'h00;
  localparam logic [15:0] CMPA_RST  = 16'h0000;
  localparam logic [7:0]  CMPP_RST  = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // Length of a full counter span, used when a compare value is zero
  localparam logic [16:0] FULL_SPAN = 17'h10000;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_CMP   = 2'b00,
    MODE_UNDEF = 2'b01,
    MODE_PWM   = 2'b10,
    MODE_TIMER = 2'b11
  } ctm_mode_e;

  // Pin action codes, compare mode and PWM mode
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_ON     = 2'h1;
  localparam logic [1:0] ACT_WAVE   = 2'h2;

  // Control word one, bit 7 down to bit 0
  typedef struct packed {
    ctm_mode_e  modeSelect;
    logic [1:0] pinAction;
    logic       pinInitialLevel;
    logic       outputInvert;
    logic       dutyPeriodSwap;
    logic       clearSourceSelect;
  } ctm_ctl1_s;

endpackage : ctm_pkg

/* ctm_prescaler.sv */
// Timer tick generator dividing the system clock by a power of two
`timescale 1ns/1ps
module ctm_prescaler
  import ctm_pkg::*;
#(
  parameter int SEL_W = PRESC_W
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Divide select, tick period is two to this power
  input  wire logic [SEL_W-1:0] divSel,
  // One-cycle tick
  output logic                  tick
);

  localparam int DIV_W = (1 << SEL_W) - 1;

  // Wider selects would need a divider past sixteen bits
  if (SEL_W < 1 || SEL_W > 4) begin : g_sel_check
    $error("ctm_prescaler: SEL_W must be 1 to 4");
  end

  logic [DIV_W-1:0] divCnt_reg;
  logic             tick_reg;

  // Mask of low bits that must all be set for a tick
  wire [DIV_W-1:0] divMask = DIV_W'((32'h1 << divSel) - 32'h1);
  wire             tick_next = (divCnt_reg & divMask) == divMask;

  // Free-running divider; a select change may shorten one period
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt_reg <= '0;
      tick_reg   <= 1'b0;
    end else begin
      divCnt_reg <= divCnt_reg + DIV_W'(1);
      tick_reg   <= tick_next;
    end
  end

  assign tick = tick_reg;

  AST_TICK_EVERY: assert property (@(posedge clk) disable iff (sys_rst)
    (divSel == '0) && $stable(divSel) |=> tick)
    else $error("tick missing at undivided rate");

endmodule : ctm_prescaler

/* ctm_pin_stage.sv */
// Output pin logic for compare and PWM modes
`timescale 1ns/1ps
module ctm_pin_stage
  import ctm_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      sys_rst,
  // Control and events
  input  wire ctm_ctl1_s ctl,
  input  wire logic      enRise,
  input  wire logic      matchAEvent,
  input  wire logic      pwmActive,
  // Pin drive
  output logic           pinOut,
  output logic           pinOutEn
);

  logic cmpLevel_reg;
  logic pinOut_reg;
  logic pinOutEn_reg;
  logic cmpLevel_next;

  // New level for a compare A match
  function automatic logic actionLevel(input logic [1:0] act, input logic cur);
    unique case (act)
      ACT_NONE:   actionLevel = cur;
      ACT_LOW:    actionLevel = 1'b0;
      ACT_HIGH:   actionLevel = 1'b1;
      ACT_TOGGLE: actionLevel = ~cur;
    endcase
  endfunction : actionLevel

  wire modeCmp = ctl.modeSelect == MODE_CMP;
  wire modePwm = ctl.modeSelect == MODE_PWM;

  // Compare level: initial on enable rise, action only on A match
  assign cmpLevel_next = enRise ? ctl.pinInitialLevel
                       : (modeCmp && matchAEvent) ? actionLevel(ctl.pinAction, cmpLevel_reg)
                       : cmpLevel_reg;

  // PWM: forced off, forced on or waveform; undefined code stays off
  wire pwmOn    = (ctl.pinAction == ACT_WAVE) ? pwmActive : (ctl.pinAction == ACT_ON);
  wire pwmLevel = pwmOn ? ctl.pinInitialLevel : ~ctl.pinInitialLevel;
  wire rawLevel = modePwm ? pwmLevel : cmpLevel_next;

  // Timer mode releases the pin to other functions
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmpLevel_reg <= 1'b0;
      pinOut_reg   <= 1'b0;
      pinOutEn_reg <= 1'b0;
    end else begin
      cmpLevel_reg <= cmpLevel_next;
      pinOut_reg   <= rawLevel ^ ctl.outputInvert;
      pinOutEn_reg <= modeCmp || modePwm;
    end
  end

  assign pinOut   = pinOut_reg;
  assign pinOutEn = pinOutEn_reg;

  AST_PIN_STILL: assert property (@(posedge clk) disable iff (sys_rst)
    modeCmp && pinOutEn && $stable(ctl) && !matchAEvent && !enRise |=> $stable(pinOut))
    else $error("compare pin moved without an A match");

  AST_PIN_TOGGLE: assert property (@(posedge clk) disable iff (sys_rst)
    modeCmp && pinOutEn && $stable(ctl) && matchAEvent && !enRise && ctl.pinAction == ACT_TOGGLE
    |=> pinOut != $past(pinOut))
    else $error("toggle action did not toggle the pin");

endmodule : ctm_pin_stage

/* ctm_compact_timer.sv */
// Compact 16-bit timer with compare, timer and PWM modes on Wishbone
//
// Function
// - Mode code 00 selects compare-match output
// - Clear select low: clear on P match
// - Clear select high: A match clears, no P flag
// - Compare A zero: overflow, no A flag
// - Compare pin changes only on A match
// - A match drives pin low, high or toggles
// - Enable rise restores initial pin level
// - Timer mode counts like compare, pin released
// - Mode code 10 is PWM, clear select ignored
// - Swap low: period P times 256, duty A
// - Swap high: period A, duty P times 256
// - Duty at or above period gives full duty
// - PWM raises a flag per comparator match
// - PWM: polarity bit and action field control pin
// - Invert bit inverts the pin
// - PWM counting continues while pin is forced
// - P compares upper byte, A all bits
// - Software clears counter only by enable rise
// - Compare action: none, low, high, toggle
// - PWM action: off, on, waveform, undefined
// - Clear select picks P match or A match
// - Initial level bit is initial or active level
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module ctm_compact_timer
  import ctm_pkg::*;
#(
  parameter int ADR_W = 8
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Match flags, sticky
  output logic                  matchAFlag,
  output logic                  matchPFlag,
  // Timer output pin
  output logic                  timerOutPin,
  output logic                  timerOutEn
);

  // Offsets reach the flags word, so five address bits at least
  if (ADR_W < 5) begin : g_adr_check
    $error("ctm_compact_timer: ADR_W must be at least 5");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  logic               ack_reg;
  logic [31:0]        rdData_reg;
  logic               enable_reg;
  logic               prevEnable_reg;
  logic [PRESC_W-1:0] presc_reg;
  ctm_ctl1_s          ctl1_reg;
  logic [15:0]        cmpA_reg;
  logic [7:0]         cmpP_reg;
  logic [15:0]        cnt_reg;
  logic [15:0]        cnt_next;
  logic               flagA_reg;
  logic               flagP_reg;
  logic               flagA_next;
  logic               flagP_next;
  logic               tick;
  logic [31:0]        rdData_next;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  ////////////////////////////////////////////////////////////////////////////

  // Request is new only while no ack is out, giving one ack per access
  wire busReq = wb_cyc_i && wb_stb_i && !ack_reg;
  wire busWr  = busReq && wb_we_i;

  // Address compare on the full bus address
  wire hitCtrl0 = wb_adr_i == ADR_W'(OFS_CTRL0);
  wire hitCtrl1 = wb_adr_i == ADR_W'(OFS_CTRL1);
  wire hitCount = wb_adr_i == ADR_W'(OFS_COUNT);
  wire hitCmpA  = wb_adr_i == ADR_W'(OFS_CMPA);
  wire hitCmpP  = wb_adr_i == ADR_W'(OFS_CMPP);
  wire hitFlags = wb_adr_i == ADR_W'(OFS_FLAGS);

  // Write strobes per register and byte lane
  wire wrCtrl0  = busWr && hitCtrl0 && wb_sel_i[0];
  wire wrCtrl1  = busWr && hitCtrl1 && wb_sel_i[0];
  wire wrCmpALo = busWr && hitCmpA && wb_sel_i[0];
  wire wrCmpAHi = busWr && hitCmpA && wb_sel_i[1];
  wire wrCmpP   = busWr && hitCmpP && wb_sel_i[0];
  wire wrFlags  = busWr && hitFlags && wb_sel_i[0];

  // Write-one-to-clear masks for the flags
  wire clrA = wrFlags && wb_dat_i[FLAG_A_BIT];
  wire clrP = wrFlags && wb_dat_i[FLAG_P_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  ////////////////////////////////////////////////////////////////////////////

  // Views of the registers, unused bits read zero
  wire [7:0] ctrl0View = (8'(enable_reg) << ENABLE_BIT) | (8'(presc_reg) << PRESC_LSB);
  wire [7:0] flagsView = (8'(flagA_reg) << FLAG_A_BIT) | (8'(flagP_reg) << FLAG_P_BIT);

  // Unmapped offsets answer with zero data
  assign rdData_next = hitCtrl0 ? {24'h000000, ctrl0View}
                : hitCtrl1 ? {24'h000000, ctl1_reg}
                : hitCount ? {16'h0000, cnt_reg}
                : hitCmpA  ? {16'h0000, cmpA_reg}
                : hitCmpP  ? {24'h000000, cmpP_reg}
                : hitFlags ? {24'h000000, flagsView}
                : 32'h00000000;

  // Ack one cycle after the request, read data captured alongside
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg    <= 1'b0;
      rdData_reg <= 32'h00000000;
    end else begin
      ack_reg    <= busReq;
      rdData_reg <= busReq ? rdData_next : rdData_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  ////////////////////////////////////////////////////////////////////////////

  // Settings only; the counter itself has no write path
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_reg <= 1'b0;
      presc_reg  <= '0;
      ctl1_reg   <= ctm_ctl1_s'(CTRL1_RST);
      cmpA_reg   <= CMPA_RST;
      cmpP_reg   <= CMPP_RST;
    end else begin
      if (wrCtrl0) begin
        enable_reg <= wb_dat_i[ENABLE_BIT];
        presc_reg  <= wb_dat_i[PRESC_LSB +: PRESC_W];
      end
      if (wrCtrl1) ctl1_reg <= ctm_ctl1_s'(wb_dat_i[7:0]);
      if (wrCmpALo) cmpA_reg[7:0] <= wb_dat_i[7:0];
      if (wrCmpAHi) cmpA_reg[15:8] <= wb_dat_i[15:8];
      if (wrCmpP) cmpP_reg <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick source
  ////////////////////////////////////////////////////////////////////////////

  ctm_prescaler #(
    .SEL_W  (PRESC_W)
  ) u_prescaler (
    .clk    (clk),
    .sys_rst(sys_rst),
    .divSel (presc_reg),
    .tick   (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode and compare decode
  ////////////////////////////////////////////////////////////////////////////

  // Mode decode; undefined code counts but drives nothing
  wire modePwm   = ctl1_reg.modeSelect == MODE_PWM;
  wire modeTimer = ctl1_reg.modeSelect == MODE_TIMER;
  wire modeCmp   = ctl1_reg.modeSelect == MODE_CMP;

  // Enable edge restarts the count
  wire enRise   = enable_reg && !prevEnable_reg;
  wire stepping = enable_reg && tick && !enRise;

  // Next count, one bit wider to see the overflow
  wire [16:0] cntInc    = {1'b0, cnt_reg} + 17'h00001;
  wire [15:0] cntIncLow = cntInc[15:0];

  // A zero compare value stands for a full 65536-tick span
  wire [16:0] spanA = (cmpA_reg == 16'h0000) ? FULL_SPAN : {1'b0, cmpA_reg};
  wire [16:0] spanP = (cmpP_reg == 8'h00) ? FULL_SPAN : {1'b0, cmpP_reg, 8'h00};

  // P sees only the upper byte, so it hits on a 256-tick boundary
  wire aHit = cntInc == spanA;
  wire pHit = cntInc == spanP;

  // Clear source: swap bit in PWM, clear select elsewhere
  wire clrByA  = modePwm ? ctl1_reg.dutyPeriodSwap : ctl1_reg.clearSourceSelect;
  wire clrHit  = clrByA ? aHit : pHit;

  // Flags: PWM raises both; compare and timer modes gate them
  wire aSet = stepping && aHit && (modePwm || cmpA_reg != 16'h0000);
  wire pSet = stepping && pHit && (modePwm || !ctl1_reg.clearSourceSelect);

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  ////////////////////////////////////////////////////////////////////////////

  // Clear on enable rise, on selected match, else wrap at the top
  assign cnt_next = enRise ? COUNT_RST
                  : !stepping ? cnt_reg
                  : clrHit ? COUNT_RST
                  : cntIncLow;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg        <= COUNT_RST;
      prevEnable_reg <= 1'b0;
    end else begin
      cnt_reg        <= cnt_next;
      prevEnable_reg <= enable_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags
  ////////////////////////////////////////////////////////////////////////////

  // A set in the clear cycle wins, so no match is lost
  assign flagA_next = aSet || (flagA_reg && !clrA);
  assign flagP_next = pSet || (flagP_reg && !clrP);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flagA_reg <= 1'b0;
      flagP_reg <= 1'b0;
    end else begin
      flagA_reg <= flagA_next;
      flagP_reg <= flagP_next;
    end
  end

  assign matchAFlag = flagA_reg;
  assign matchPFlag = flagP_reg;

  ////////////////////////////////////////////////////////////////////////////
  // PWM waveform
  ////////////////////////////////////////////////////////////////////////////

  // Duty and period lengths by swap bit
  wire [16:0] dutyLen   = ctl1_reg.dutyPeriodSwap ? spanP : {1'b0, cmpA_reg};
  wire [16:0] periodLen = ctl1_reg.dutyPeriodSwap ? spanA : spanP;

  // Count stays below period, so duty at or over it is always on
  wire pwmActive = {1'b0, cnt_reg} < dutyLen;

  // Runs regardless of the pin action, forced levels included
  ctm_pin_stage u_pin_stage (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .ctl        (ctl1_reg),
    .enRise     (enRise),
    .matchAEvent(aSet),
    .pwmActive  (pwmActive),
    .pinOut     (timerOutPin),
    .pinOutEn   (timerOutEn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_CNT_STEP: assert property (
    stepping && !clrHit |=> cnt_reg == $past(cntIncLow))
    else $error("counter did not step by one");

  AST_CNT_CLEAR: assert property (
    stepping && clrHit |=> cnt_reg == 16'h0000)
    else $error("counter not cleared on selected match");

  AST_EN_RISE: assert property (
    !enable_reg ##1 enable_reg |=> cnt_reg == 16'h0000)
    else $error("enable rise did not clear the counter");

  AST_CNT_HOLD: assert property (
    !stepping && !enRise |=> $stable(cnt_reg))
    else $error("counter changed while not stepping");

  AST_NO_P_FLAG: assert property (
    !modePwm && ctl1_reg.clearSourceSelect && !flagP_reg |=> !flagP_reg)
    else $error("P flag raised with A clear source");

  AST_A_ZERO: assert property (
    (modeCmp || modeTimer) && cmpA_reg == 16'h0000 && !flagA_reg |=> !flagA_reg)
    else $error("A flag raised with zero compare A");

  AST_FLAG_SET_WINS: assert property (
    aSet && clrA |=> flagA_reg)
    else $error("A flag lost against a clear");

  AST_PWM_FULL: assert property (
    modePwm && enable_reg && dutyLen >= periodLen |-> pwmActive)
    else $error("full duty not reached");

  AST_TIMER_NO_PIN: assert property (
    modeTimer [*2] |-> !timerOutEn)
    else $error("pin driven in timer mode");

  AST_WB_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  AST_WB_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after a request");

  AST_P_UPPER: assert property (
    pSet |-> cnt_reg[7:0] == 8'hFF && cnt_reg[15:8] == 8'(cmpP_reg - 8'h01))
    else $error("P match away from its upper byte boundary");

  AST_A_FULL: assert property (
    aSet |-> cnt_reg == 16'(cmpA_reg - 16'h0001))
    else $error("A match away from the full compare value");

  AST_A_STICKY: assert property (
    flagA_reg && !clrA |=> flagA_reg)
    else $error("A flag dropped without a clear");

  AST_P_STICKY: assert property (
    flagP_reg && !clrP |=> flagP_reg)
    else $error("P flag dropped without a clear");

  // Pin follows the waveform, active level and invert bit one edge later
  AST_PWM_PIN: assert property (
    modePwm && ctl1_reg.pinAction == ACT_WAVE
    |=> timerOutPin == (($past(pwmActive) ~^ $past(ctl1_reg.pinInitialLevel)) ^ $past(ctl1_reg.outputInvert)))
    else $error("PWM pin does not follow the waveform");

endmodule : ctm_compact_timer

/* ctm_compact_timer_test.sv */
// Self-checking bench for the compact timer: bus, compare, timer and PWM modes
`timescale 1ns/1ps
module ctm_compact_timer_test
  import ctm_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  // Bench signals
  logic        clk;
  logic        sys_rst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datI;
  logic [31:0] datO;
  logic        ack;
  logic        flagA;
  logic        flagP;
  logic        pin;
  logic        pinEn;
  logic [31:0] expQ[$];
  logic [15:0] cmpA;
  int          badCount;
  int          compares;
  int          seed;

  ctm_compact_timer #(.ADR_W(8)) i_ctm_compact_timer (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .wb_cyc_i   (cyc),
    .wb_stb_i   (stb),
    .wb_we_i    (we),
    .wb_adr_i   (adr),
    .wb_sel_i   (sel),
    .wb_dat_i   (datI),
    .wb_dat_o   (datO),
    .wb_ack_o   (ack),
    .matchAFlag (flagA),
    .matchPFlag (flagP),
    .timerOutPin(pin),
    .timerOutEn (pinEn)
  );

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, badCount);
    if (badCount == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic chkBit(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask : chkBit

  task automatic timeout(input string what);
    badCount++;
    $display("wrong value %s expected event seen timeout", what);
    summarize();
  endtask : timeout

  ////////////////////////////////////////////////////////////////////////////
  // Bus master, one classic cycle; waits for ack without assuming latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'h3;
    datI <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) timeout("bus ack");
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  // Expected read data is queued; the watcher below compares it at ack
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  // Read watcher, ack and direction seen as sampled at the edge
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expQ.size() == 0) begin
        badCount++;
        $display("wrong value read data expected none seen %0h", datO);
      end else begin
        chk("read data", expQ.pop_front(), datO);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer helpers
  function automatic logic [7:0] c1(input logic [1:0] m, input logic [1:0] act, input logic oc,
                                    input logic inv, input logic dpx, input logic ccs);
    return {m, act, oc, inv, dpx, ccs};
  endfunction : c1

  // Stop, load, clear flags, then start so that enable always rises
  task automatic setup(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] p);
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_CMPA, {16'h0, a});
    wr(OFS_CMPP, {24'h0, p});
    wr(OFS_CTRL1, {24'h0, ctl});
    wr(OFS_FLAGS, 32'h3);
    wr(OFS_CTRL0, 32'h8);
  endtask : setup

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic waitPin(input logic v, output int cnt);
    cnt = 0;
    while (pin !== v) begin
      @(posedge clk);
      cnt++;
      if (cnt > 70000) timeout("pin level");
    end
  endtask : waitPin

  // Skips the partial first wave, then times one high phase and one period
  task automatic measure(input logic [31:0] eHi, input logic [31:0] ePer);
    int c;
    int hi;
    int lo;
    waitPin(1'b0, c);
    waitPin(1'b1, c);
    waitPin(1'b0, hi);
    waitPin(1'b1, lo);
    chk("high time", eHi, 32'(hi));
    chk("period", ePer, 32'(hi + lo));
  endtask : measure

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'hFF7B;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h3;
    datI = 32'h0;
    badCount = 0;
    compares = 0;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values, then an unmapped place
    rd(OFS_CTRL1, 32'h0);
    rd(OFS_CMPA, 32'h0);
    rd(OFS_CMPP, 32'h0);
    rd(OFS_FLAGS, 32'h0);
    rd(8'h18, 32'h0);
    chkBit("pin enable", 1'b1, pinEn);
    // Short run then stop: count must hold, writes to it ignored
    wr(OFS_CTRL0, 32'h8);
    wr(OFS_CTRL0, 32'h0);
    rd(OFS_COUNT, 32'h2);
    wr(OFS_COUNT, 32'hFFFF);
    rd(OFS_COUNT, 32'h2);
    wr(OFS_CMPA, 32'hA55A);
    rd(OFS_CMPA, 32'hA55A);
    // Every compare action from both initial levels
    for (int il = 0; il < 2; il++) begin
      for (int act = 0; act < 4; act++) begin
        logic e;
        e = (act == 0) ? il[0] : (act == 1) ? 1'b0 : (act == 2) ? 1'b1 : ~il[0];
        setup(c1(2'b00, act[1:0], il[0], 1'b0, 1'b0, 1'b1), 16'd40, 8'h0);
        idle(2);
        chkBit("initial pin", il[0], pin);
        idle(60);
        chkBit("pin after A match", e, pin);
      end
    end
    // Random compare A above the P span; toggling shows the A period
    cmpA = 16'd300 + 16'($random(seed) & 32'h3F);
    setup(c1(2'b00, 2'b11, 1'b0, 1'b0, 1'b0, 1'b1), cmpA, 8'h1);
    measure({16'h0, cmpA}, {15'h0, cmpA, 1'b0});
    chkBit("P flag", 1'b0, flagP);
    chkBit("A flag", 1'b1, flagA);
    // Clear on P match with an A match inside the span
    setup(c1(2'b00, 2'b10, 1'b0, 1'b0, 1'b0, 1'b0), 16'd100, 8'h1);
    idle(300);
    chkBit("A flag", 1'b1, flagA);
    chkBit("P flag", 1'b1, flagP);
    chkBit("pin high", 1'b1, pin);
    // A beyond the P span never matches; P alone leaves the pin
    setup(c1(2'b00, 2'b11, 1'b0, 1'b0, 1'b0, 1'b0), 16'd300, 8'h1);
    idle(600);
    chkBit("A flag", 1'b0, flagA);
    chkBit("P flag", 1'b1, flagP);
    chkBit("pin held", 1'b0, pin);
    // Compare A zero with A as clear source
    setup(c1(2'b00, 2'b11, 1'b0, 1'b0, 1'b0, 1'b1), 16'h0, 8'h1);
    idle(600);
    chkBit("A flag", 1'b0, flagA);
    chkBit("P flag", 1'b0, flagP);
    // Undefined mode code counts like compare but leaves the pin alone
    setup(c1(2'b01, 2'b11, 1'b0, 1'b0, 1'b0, 1'b1), 16'd40, 8'h0);
    idle(60);
    chkBit("pin enable", 1'b0, pinEn);
    chkBit("A flag", 1'b1, flagA);
    // Tick every second clock doubles the toggle time
    setup(c1(2'b00, 2'b11, 1'b0, 1'b0, 1'b0, 1'b1), 16'd40, 8'h0);
    wr(OFS_CTRL0, 32'h18);
    measure(32'd80, 32'd160);
    // Timer mode releases the pin but keeps the flags
    setup(c1(2'b11, 2'b11, 1'b1, 1'b0, 1'b0, 1'b1), 16'd40, 8'h0);
    idle(60);
    chkBit("pin enable", 1'b0, pinEn);
    chkBit("A flag", 1'b1, flagA);
    // PWM waveforms, clear select set where it must not matter
    setup(c1(2'b10, 2'b10, 1'b1, 1'b0, 1'b0, 1'b1), 16'd128, 8'h2);
    measure(32'd128, 32'd512);
    chkBit("pin enable", 1'b1, pinEn);
    setup(c1(2'b10, 2'b10, 1'b1, 1'b0, 1'b1, 1'b0), 16'd300, 8'h1);
    measure(32'd256, 32'd300);
    setup(c1(2'b10, 2'b10, 1'b1, 1'b1, 1'b0, 1'b0), 16'd64, 8'h1);
    measure(32'd192, 32'd256);
    // Duty above period stays active throughout
    setup(c1(2'b10, 2'b10, 1'b1, 1'b0, 1'b1, 1'b0), 16'd200, 8'h1);
    idle(5);
    begin
      int ones;
      ones = 0;
      repeat (400) begin
        @(posedge clk);
        if (pin === 1'b1) ones++;
      end
      chk("full duty", 32'd400, 32'(ones));
    end
    // Forced levels for both polarities; matching must go on underneath
    for (int oc = 0; oc < 2; oc++) begin
      for (int k = 0; k < 3; k++) begin
        logic [1:0] act;
        act = (k == 2) ? 2'b11 : k[1:0];
        setup(c1(2'b10, act, oc[0], 1'b0, 1'b0, 1'b0), 16'd64, 8'h1);
        idle(600);
        chkBit("forced pin", (act == 2'b01) ? oc[0] : ~oc[0], pin);
        chkBit("A flag", 1'b1, flagA);
        chkBit("P flag", 1'b1, flagP);
      end
    end
    summarize();
  end

endmodule : ctm_compact_timer_test
